/* shared/xsfr_cfg.svh */
// constants for the data-pointer extension and port sfr block
// Function
// - the pointer select register picks which of two data pointers all pointer instructions use.
// - the four extension registers shape addresses only for external data moves.
// - a pointer-based external data move takes its top byte from the selected pointer's extension.
// - an R0/external data move takes its top byte from top_extension, middle from page_extension.
// - the external data space is 24 bits wide; on-chip units decode to small regions in its lower half.
// - addresses 0x800000 to 0xFFFFFF go to the external memory interface.
// - sram, clock control, port control and every other unit decode to fixed regions.
// - ports 0-6, 12 and 15 each get an output-data, pin-state and output-select register.
// - a select bit of 1 drives that pin from the sfr output-data bit.
// - a select bit of 0 drives that pin from the hub-side port data bit.
// - the pin-state register is read-only and shows the sampled pin levels.
// - the port registers are reachable over both the sfr path and the peripheral hub.
// - direct accesses to the upper 128 bytes reach sfrs, indirect ones reach ram.
`ifndef XSFR_CFG_SVH
`define XSFR_CFG_SVH

`define XSFR_RST_BYTE  8'h00
`define XSFR_SFR_BASE  8'h80
`define XSFR_A_LO0     8'h82
`define XSFR_A_HI0     8'h83
`define XSFR_A_LO1     8'h84
`define XSFR_A_HI1     8'h85
`define XSFR_A_PSEL    8'h86
`define XSFR_A_EXT0    8'h93
`define XSFR_A_EXT1    8'h95
`define XSFR_A_PAGE    8'hA0
`define XSFR_A_TOP     8'hEA

// per-port addresses, entry 0 is port 0, entry 8 is port 15
`define XSFR_NPORTS    9
`define XSFR_DR_TAB    {8'hF8,8'hE8,8'hD8,8'hC8,8'hC0,8'hB0,8'h98,8'h90,8'h80}
`define XSFR_PS_TAB    {8'hF9,8'hE9,8'hD9,8'hC9,8'hC1,8'hB1,8'h99,8'h91,8'h89}
`define XSFR_SEL_TAB   {8'hFA,8'hF2,8'hDA,8'hCA,8'hC2,8'hB2,8'h9A,8'hA2,8'h8A}

// data-space regions {lo,hi}; entry i is region code i+1, code 0 is unmapped
`define XSFR_NRGN      22
`define XSFR_RGN_EXT   5'h16
`define XSFR_RGN_TAB { \
    24'h800000,24'hFFFFFF, 24'h080000,24'h081FFF, 24'h050220,24'h0502F0, \
    24'h010000,24'h01FFFF, 24'h00C000,24'h00C800, 24'h00A000,24'h00A400, \
    24'h008000,24'h008FFF, 24'h007000,24'h007FFF, 24'h006400,24'h006FFF, \
    24'h006000,24'h0060FF, 24'h005800,24'h005FFF, 24'h005400,24'h0054FF, \
    24'h005000,24'h0051FF, 24'h004F00,24'h004FFF, 24'h004E00,24'h004EFF, \
    24'h004900,24'h0049FF, 24'h004700,24'h0047FF, 24'h004500,24'h0045FF, \
    24'h004400,24'h0044FF, 24'h004300,24'h0043FF, 24'h004000,24'h0042FF, \
    24'h000000,24'h001FFF}

`endif

/* shared/xsfr_pkg.sv */
// types for the data-pointer extension and port sfr block
package xsfr_pkg;

    typedef logic [4:0] xsfr_region_type;

    typedef enum logic [1:0] {
        XSFR_REG_DATA  = 2'b00,
        XSFR_REG_STATE = 2'b01,
        XSFR_REG_SEL   = 2'b10
    } xsfr_kind_type;

    typedef struct packed {
        logic       req;
        logic       use_ri;
        logic [7:0] ri_val;
    } xsfr_move_type;

    typedef struct packed {
        logic                 req;
        logic                 wr;
        logic [3:0]           port;
        xsfr_kind_type        kind;
        logic [7:0]           wdata;
    } xsfr_hub_type;

endpackage

/* verilog/xsfr_top.sv */
// data pointers, xdata address extension, decoder and sfr-side ports
`timescale 1ns/10ps
`include "xsfr_cfg.svh"

module xsfr_top #(
    parameter int NPORTS = `XSFR_NPORTS
) (
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    input  wire logic [7:0]                 sfr_addr_in,
    input  wire logic                       sfr_wr_in,
    input  wire logic                       sfr_rd_in,
    input  wire logic [7:0]                 sfr_wdata_in,
    output logic      [7:0]                 sfr_rdata_out,
    output logic                            sfr_hit_out,
    input  wire logic                       ptr_inc_in,
    input  wire logic                       ptr_load_in,
    input  wire logic [15:0]                ptr_imm_in,
    output logic      [15:0]                ptr_sel_out,
    input  wire xsfr_pkg::xsfr_move_type    move_in,
    output logic      [23:0]                xaddr_out,
    output logic                            xaddr_valid_out,
    output xsfr_pkg::xsfr_region_type       region_out,
    output logic                            ext_mem_sel_out,
    input  wire logic                       idata_req_in,
    input  wire logic                       idata_direct_in,
    input  wire logic [7:0]                 idata_addr_in,
    output logic                            idata_to_sfr_out,
    output logic                            idata_to_ram_out,
    input  wire xsfr_pkg::xsfr_hub_type     hub_in,
    output logic      [7:0]                 hub_rdata_out,
    input  wire logic [NPORTS-1:0][7:0]     hub_port_data_in,
    input  wire logic [NPORTS-1:0][7:0]     pin_in,
    output logic      [NPORTS-1:0][7:0]     pin_out
);

    localparam logic [NPORTS*8-1:0]    DR_TAB  = `XSFR_DR_TAB;
    localparam logic [NPORTS*8-1:0]    PS_TAB  = `XSFR_PS_TAB;
    localparam logic [NPORTS*8-1:0]    SEL_TAB = `XSFR_SEL_TAB;
    localparam logic [`XSFR_NRGN*48-1:0] RGN_TAB = `XSFR_RGN_TAB;

    logic [7:0]              lo0_q;
    logic [7:0]              hi0_q;
    logic [7:0]              lo1_q;
    logic [7:0]              hi1_q;
    logic                    psel_q;
    logic [7:0]              ext0_q;
    logic [7:0]              ext1_q;
    logic [7:0]              page_q;
    logic [7:0]              top_q;
    logic [NPORTS-1:0][7:0]  dr_q;
    logic [NPORTS-1:0][7:0]  sel_q;
    logic [NPORTS-1:0][7:0]  ps_q;
    logic [15:0]             ptr_cur;
    logic [15:0]             ptr_next;
    logic [23:0]             xaddr_d;
    xsfr_pkg::xsfr_region_type region_d;
    logic [7:0]              rdata_d;
    logic                    hit_d;
    logic [7:0]              hub_rdata_d;
    logic                    sfr_we;

    // sfr writes only land when the core addresses the sfr half
    assign sfr_we  = sfr_wr_in && (sfr_addr_in >= `XSFR_SFR_BASE);
    assign ptr_cur = psel_q ? {hi1_q, lo1_q} : {hi0_q, lo0_q};
    assign ptr_next = ptr_load_in ? ptr_imm_in : ptr_cur + 16'h0001;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            psel_q <= 1'b0;
        end
        else if (sfr_we && sfr_addr_in == `XSFR_A_PSEL)
        begin
            psel_q <= sfr_wdata_in[0];
        end
    end

    // pointer instructions win over a same-cycle sfr write to the pointer
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            lo0_q <= `XSFR_RST_BYTE;
            hi0_q <= `XSFR_RST_BYTE;
            lo1_q <= `XSFR_RST_BYTE;
            hi1_q <= `XSFR_RST_BYTE;
        end
        else
        begin
            if (sfr_we && sfr_addr_in == `XSFR_A_LO0)
                lo0_q <= sfr_wdata_in;
            if (sfr_we && sfr_addr_in == `XSFR_A_HI0)
                hi0_q <= sfr_wdata_in;
            if (sfr_we && sfr_addr_in == `XSFR_A_LO1)
                lo1_q <= sfr_wdata_in;
            if (sfr_we && sfr_addr_in == `XSFR_A_HI1)
                hi1_q <= sfr_wdata_in;
            if ((ptr_inc_in || ptr_load_in) && !psel_q)
            begin
                {hi0_q, lo0_q} <= ptr_next;
            end
            if ((ptr_inc_in || ptr_load_in) && psel_q)
            begin
                {hi1_q, lo1_q} <= ptr_next;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ext0_q <= `XSFR_RST_BYTE;
            ext1_q <= `XSFR_RST_BYTE;
            page_q <= `XSFR_RST_BYTE;
            top_q  <= `XSFR_RST_BYTE;
        end
        else
        begin
            if (sfr_we && sfr_addr_in == `XSFR_A_EXT0)
                ext0_q <= sfr_wdata_in;
            if (sfr_we && sfr_addr_in == `XSFR_A_EXT1)
                ext1_q <= sfr_wdata_in;
            if (sfr_we && sfr_addr_in == `XSFR_A_PAGE)
                page_q <= sfr_wdata_in;
            if (sfr_we && sfr_addr_in == `XSFR_A_TOP)
                top_q <= sfr_wdata_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            ptr_sel_out <= 16'h0000;
        else
            ptr_sel_out <= ptr_cur;
    end

    // address formation for external data moves
    always_comb
    begin
        if (move_in.use_ri)
            xaddr_d = {top_q, page_q, move_in.ri_val};
        else if (psel_q)
            xaddr_d = {ext1_q, ptr_cur};
        else
            xaddr_d = {ext0_q, ptr_cur};
    end

    // first matching entry wins; table regions never overlap
    always_comb
    begin
        region_d = 5'h00;
        for (int i = `XSFR_NRGN - 1; i >= 0; i--)
        begin
            if (xaddr_d >= RGN_TAB[i*48+24 +: 24] && xaddr_d <= RGN_TAB[i*48 +: 24])
                region_d = 5'(i + 1);
        end
    end

    // other instructions leave the extension address untouched
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            xaddr_out       <= 24'h000000;
            xaddr_valid_out <= 1'b0;
            region_out      <= 5'h00;
            ext_mem_sel_out <= 1'b0;
        end
        else
        begin
            xaddr_valid_out <= move_in.req;
            ext_mem_sel_out <= move_in.req && region_d == `XSFR_RGN_EXT;
            if (move_in.req)
            begin
                xaddr_out  <= xaddr_d;
                region_out <= region_d;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            idata_to_sfr_out <= 1'b0;
            idata_to_ram_out <= 1'b0;
        end
        else
        begin
            idata_to_sfr_out <= idata_req_in && idata_direct_in
                                && idata_addr_in >= `XSFR_SFR_BASE;
            idata_to_ram_out <= idata_req_in && !(idata_direct_in
                                && idata_addr_in >= `XSFR_SFR_BASE);
        end
    end

    // per-port registers; sfr write wins over a hub write in the same cycle
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_port
        logic hub_hit;
        assign hub_hit = hub_in.req && hub_in.wr && hub_in.port == 4'(p);

        always_ff @(posedge clk_in)
        begin
            if (reset_in)
            begin
                dr_q[p]  <= `XSFR_RST_BYTE;
                sel_q[p] <= `XSFR_RST_BYTE;
            end
            else
            begin
                if (sfr_we && sfr_addr_in == DR_TAB[p*8 +: 8])
                    dr_q[p] <= sfr_wdata_in;
                else if (hub_hit && hub_in.kind == xsfr_pkg::XSFR_REG_DATA)
                    dr_q[p] <= hub_in.wdata;
                if (sfr_we && sfr_addr_in == SEL_TAB[p*8 +: 8])
                    sel_q[p] <= sfr_wdata_in;
                else if (hub_hit && hub_in.kind == xsfr_pkg::XSFR_REG_SEL)
                    sel_q[p] <= hub_in.wdata;
            end
        end

        // pin state has no write path at all
        always_ff @(posedge clk_in)
        begin
            if (reset_in)
                ps_q[p] <= `XSFR_RST_BYTE;
            else
                ps_q[p] <= pin_in[p];
        end

        always_ff @(posedge clk_in)
        begin
            if (reset_in)
                pin_out[p] <= `XSFR_RST_BYTE;
            else
                pin_out[p] <= (sel_q[p] & dr_q[p]) | (~sel_q[p] & hub_port_data_in[p]);
        end
    end

    // sfr read mux; unmapped sfr addresses read zero and drop hit
    always_comb
    begin
        rdata_d = 8'h00;
        hit_d   = 1'b1;
        case (sfr_addr_in)
            `XSFR_A_LO0:  rdata_d = lo0_q;
            `XSFR_A_HI0:  rdata_d = hi0_q;
            `XSFR_A_LO1:  rdata_d = lo1_q;
            `XSFR_A_HI1:  rdata_d = hi1_q;
            `XSFR_A_PSEL: rdata_d = {7'h00, psel_q};
            `XSFR_A_EXT0: rdata_d = ext0_q;
            `XSFR_A_EXT1: rdata_d = ext1_q;
            `XSFR_A_PAGE: rdata_d = page_q;
            `XSFR_A_TOP:  rdata_d = top_q;
            default:      hit_d   = 1'b0;
        endcase
        for (int i = 0; i < NPORTS; i++)
        begin
            if (sfr_addr_in == DR_TAB[i*8 +: 8])
            begin
                rdata_d = dr_q[i];
                hit_d   = 1'b1;
            end
            if (sfr_addr_in == PS_TAB[i*8 +: 8])
            begin
                rdata_d = ps_q[i];
                hit_d   = 1'b1;
            end
            if (sfr_addr_in == SEL_TAB[i*8 +: 8])
            begin
                rdata_d = sel_q[i];
                hit_d   = 1'b1;
            end
        end
        if (sfr_addr_in < `XSFR_SFR_BASE)
            hit_d = 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sfr_rdata_out <= 8'h00;
            sfr_hit_out   <= 1'b0;
        end
        else
        begin
            sfr_rdata_out <= (sfr_rd_in && hit_d) ? rdata_d : 8'h00;
            sfr_hit_out   <= (sfr_rd_in || sfr_wr_in) && hit_d;
        end
    end

    // hub read of the same port registers
    always_comb
    begin
        hub_rdata_d = 8'h00;
        for (int i = 0; i < NPORTS; i++)
        begin
            if (hub_in.port == 4'(i))
            begin
                case (hub_in.kind)
                    xsfr_pkg::XSFR_REG_DATA:  hub_rdata_d = dr_q[i];
                    xsfr_pkg::XSFR_REG_STATE: hub_rdata_d = ps_q[i];
                    xsfr_pkg::XSFR_REG_SEL:   hub_rdata_d = sel_q[i];
                    default:                  hub_rdata_d = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            hub_rdata_out <= 8'h00;
        else
            hub_rdata_out <= (hub_in.req && !hub_in.wr) ? hub_rdata_d : 8'h00;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_dptr_top_byte: assert property (move_in.req && !move_in.use_ri |=>
        xaddr_out[23:16] == ($past(psel_q) ? $past(ext1_q) : $past(ext0_q)))
        else $error("pointer move top byte wrong");

    a_ri_addr_bytes: assert property (move_in.req && move_in.use_ri |=>
        xaddr_out[23:8] == {$past(top_q), $past(page_q)})
        else $error("register move upper bytes wrong");

    a_ri_low_byte: assert property (move_in.req && move_in.use_ri |=>
        xaddr_out[7:0] == $past(move_in.ri_val))
        else $error("register move low byte wrong");

    a_addr_hold_idle: assert property (!move_in.req |=> $stable(xaddr_out))
        else $error("address changed without a move");

    a_ext_mem_route: assert property (xaddr_valid_out |->
        ext_mem_sel_out == xaddr_out[23])
        else $error("external window routing wrong");

    a_sram_region: assert property (xaddr_valid_out && xaddr_out <= 24'h001FFF |->
        region_out == 5'h01)
        else $error("sram region not decoded");

    a_ptr_inc_step: assert property (ptr_inc_in && !ptr_load_in && !sfr_wr_in
        |=> ##1 ptr_sel_out == $past(ptr_cur, 2) + 16'h0001)
        else $error("pointer increment wrong");

    // read data shows the pin level registered one edge before the read is taken
    a_pin_state_ro: assert property (sfr_rd_in && sfr_addr_in == PS_TAB[7:0]
        && !$past(reset_in) |=> sfr_rdata_out == $past(pin_in[0], 2))
        else $error("pin state readback wrong");

    a_pin_src_sel: assert property (##1 1'b1 |-> pin_out[0] ==
        (($past(sel_q[0]) & $past(dr_q[0])) | (~$past(sel_q[0]) & $past(hub_port_data_in[0]))))
        else $error("pin source select wrong");

    a_idata_split: assert property (idata_req_in |=>
        idata_to_sfr_out != idata_to_ram_out)
        else $error("internal data routing wrong");

endmodule

/* verif/xsfr_cpu_model.sv */
// cpu-side model issuing sfr, pointer, move and internal-data requests
`timescale 1ns/10ps

module xsfr_cpu_model (
    input  wire logic                    clk_in,
    output logic      [7:0]              sfr_addr_out,
    output logic                         sfr_wr_out,
    output logic                         sfr_rd_out,
    output logic      [7:0]              sfr_wdata_out,
    input  wire logic [7:0]              sfr_rdata_in,
    input  wire logic                    sfr_hit_in,
    output logic                         ptr_inc_out,
    output logic                         ptr_load_out,
    output logic      [15:0]             ptr_imm_out,
    output xsfr_pkg::xsfr_move_type      move_out,
    input  wire logic [23:0]             xaddr_in,
    input  wire logic                    xaddr_valid_in,
    input  wire xsfr_pkg::xsfr_region_type region_in,
    input  wire logic                    ext_mem_sel_in,
    output logic                         idata_req_out,
    output logic                         idata_direct_out,
    output logic      [7:0]              idata_addr_out
);

    initial
    begin
        sfr_addr_out = 8'h00;
        sfr_wr_out = 1'b0;
        sfr_rd_out = 1'b0;
        sfr_wdata_out = 8'h00;
        ptr_inc_out = 1'b0;
        ptr_load_out = 1'b0;
        ptr_imm_out = 16'h0000;
        move_out = '0;
        idata_req_out = 1'b0;
        idata_direct_out = 1'b0;
        idata_addr_out = 8'h00;
    end

    // released lines show the inverse so stale values cannot pass for answers
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        sfr_addr_out = a;
        sfr_wdata_out = d;
        sfr_wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        sfr_wr_out = 1'b0;
        sfr_addr_out = ~a;
        sfr_wdata_out = ~d;
    endtask

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge clk_in);
        #1;
        sfr_addr_out = a;
        sfr_rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        sfr_rd_out = 1'b0;
        sfr_addr_out = ~a;
        d = sfr_rdata_in;
        h = sfr_hit_in;
    endtask

    task automatic ptr_op(input logic ld, input logic [15:0] imm);
        @(posedge clk_in);
        #1;
        ptr_load_out = ld;
        ptr_inc_out = ~ld;
        ptr_imm_out = imm;
        @(posedge clk_in);
        #1;
        ptr_load_out = 1'b0;
        ptr_inc_out = 1'b0;
        ptr_imm_out = ~imm;
    endtask

    task automatic xmove(input logic ri_mode, input logic [7:0] ri, output logic [23:0] xa,
                         output xsfr_pkg::xsfr_region_type rg, output logic v, output logic e);
        @(posedge clk_in);
        #1;
        move_out = '{req: 1'b1, use_ri: ri_mode, ri_val: ri};
        @(posedge clk_in);
        #1;
        move_out.req = 1'b0;
        move_out.ri_val = ~ri;
        xa = xaddr_in;
        rg = region_in;
        v = xaddr_valid_in;
        e = ext_mem_sel_in;
    endtask

    task automatic idata(input logic dir, input logic [7:0] a);
        @(posedge clk_in);
        #1;
        idata_req_out = 1'b1;
        idata_direct_out = dir;
        idata_addr_out = a;
        @(posedge clk_in);
        #1;
        idata_req_out = 1'b0;
        idata_addr_out = ~a;
    endtask

endmodule

/* verif/xsfr_top_test.sv */
// self-checking bench for the pointer extension and port sfr block
`timescale 1ns/10ps
`include "xsfr_cfg.svh"

module xsfr_top_test;

    localparam int              NP     = `XSFR_NPORTS;
    localparam logic [8:0][7:0] DR_TAB = `XSFR_DR_TAB;
    localparam logic [8:0][7:0] PS_TAB = `XSFR_PS_TAB;
    localparam logic [8:0][7:0] SL_TAB = `XSFR_SEL_TAB;

    logic                    clk_in;
    logic                    reset_in;
    logic [7:0]              sfr_addr;
    logic                    sfr_wr;
    logic                    sfr_rd;
    logic [7:0]              sfr_wdata;
    logic [7:0]              sfr_rdata_out;
    logic                    sfr_hit_out;
    logic                    ptr_inc;
    logic                    ptr_load;
    logic [15:0]             ptr_imm;
    logic [15:0]             ptr_sel_out;
    xsfr_pkg::xsfr_move_type move;
    logic [23:0]             xaddr_out;
    logic                    xaddr_valid_out;
    xsfr_pkg::xsfr_region_type region_out;
    logic                    ext_mem_sel_out;
    logic                    idata_req;
    logic                    idata_direct;
    logic [7:0]              idata_addr;
    logic                    idata_to_sfr_out;
    logic                    idata_to_ram_out;
    xsfr_pkg::xsfr_hub_type  hub_in;
    logic [7:0]              hub_rdata_out;
    logic [NP-1:0][7:0]      hub_port_data_in;
    logic [NP-1:0][7:0]      pin_in;
    logic [NP-1:0][7:0]      pin_out;
    int                      err_count;
    int                      comparisons;
    logic [7:0]              q;

    xsfr_top #(.NPORTS(NP)) u_xsfr_top (
        .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr),
        .sfr_rd_in(sfr_rd), .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata_out),
        .sfr_hit_out(sfr_hit_out), .ptr_inc_in(ptr_inc), .ptr_load_in(ptr_load),
        .ptr_imm_in(ptr_imm), .ptr_sel_out(ptr_sel_out), .move_in(move), .xaddr_out(xaddr_out),
        .xaddr_valid_out(xaddr_valid_out), .region_out(region_out), .ext_mem_sel_out(ext_mem_sel_out),
        .idata_req_in(idata_req), .idata_direct_in(idata_direct), .idata_addr_in(idata_addr),
        .idata_to_sfr_out(idata_to_sfr_out), .idata_to_ram_out(idata_to_ram_out), .hub_in(hub_in),
        .hub_rdata_out(hub_rdata_out), .hub_port_data_in(hub_port_data_in), .pin_in(pin_in),
        .pin_out(pin_out));

    xsfr_cpu_model u_xsfr_cpu_model (
        .clk_in(clk_in), .sfr_addr_out(sfr_addr), .sfr_wr_out(sfr_wr), .sfr_rd_out(sfr_rd),
        .sfr_wdata_out(sfr_wdata), .sfr_rdata_in(sfr_rdata_out), .sfr_hit_in(sfr_hit_out),
        .ptr_inc_out(ptr_inc), .ptr_load_out(ptr_load), .ptr_imm_out(ptr_imm), .move_out(move),
        .xaddr_in(xaddr_out), .xaddr_valid_in(xaddr_valid_out), .region_in(region_out),
        .ext_mem_sel_in(ext_mem_sel_out), .idata_req_out(idata_req), .idata_direct_out(idata_direct),
        .idata_addr_out(idata_addr));

    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic print_verdict;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_xsfr_cpu_model.sfr_write(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        logic [7:0] d;
        logic       h;
        u_xsfr_cpu_model.sfr_read(a, d, h);
        check({16'h0000, d}, {16'h0000, exp});
        check({23'h0, h}, {23'h0, hit});
    endtask

    task automatic mv_chk(input logic rim, input logic [7:0] ri, input logic [23:0] ea, input logic [4:0] er);
        logic [23:0]               xa;
        xsfr_pkg::xsfr_region_type rg;
        logic                      v;
        logic                      e;
        u_xsfr_cpu_model.xmove(rim, ri, xa, rg, v, e);
        check(xa, ea);
        check(24'(rg), 24'(er));
        check({22'h0, v, e}, {22'h0, 1'b1, ea[23]});
    endtask

    task automatic ptr_chk(input logic [15:0] exp);
        @(posedge clk_in);
        #1;
        check({8'h00, ptr_sel_out}, {8'h00, exp});
    endtask

    task automatic hub_op(input logic w, input logic [3:0] p, input xsfr_pkg::xsfr_kind_type k,
                          input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_in);
        #1;
        hub_in = '{req: 1'b1, wr: w, port: p, kind: k, wdata: d};
        @(posedge clk_in);
        #1;
        r = hub_rdata_out;
        hub_in.req = 1'b0;
        hub_in.wdata = ~d;
    endtask

    task automatic idata_chk(input logic dir, input logic [7:0] a, input logic to_sfr);
        u_xsfr_cpu_model.idata(dir, a);
        check({22'h0, idata_to_sfr_out, idata_to_ram_out}, {22'h0, to_sfr, ~to_sfr});
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        print_verdict();
    end

    initial
    begin
        err_count = 0;
        comparisons = 0;
        reset_in = 1'b1;
        hub_in = '0;
        hub_port_data_in = '0;
        for (int i = 0; i < NP; i++)
            pin_in[i] = 8'h5A ^ 8'(i);
        repeat (16) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        // reset contents, read-only pin state, unmapped and low addresses
        for (int i = 0; i < NP; i++)
        begin
            rd_chk(DR_TAB[i], 8'h00, 1'b1);
            rd_chk(SL_TAB[i], 8'h00, 1'b1);
            wr(PS_TAB[i], 8'hFF);
            rd_chk(PS_TAB[i], 8'h5A ^ 8'(i), 1'b1);
        end
        rd_chk(`XSFR_A_PSEL, 8'h00, 1'b1);
        rd_chk(`XSFR_A_TOP, 8'h00, 1'b1);
        rd_chk(8'hB8, 8'h00, 1'b0);
        rd_chk(8'h7F, 8'h00, 1'b0);
        // per-pin source select between sfr and hub data
        for (int i = 0; i < NP; i++)
        begin
            hub_port_data_in[i] = 8'hA5;
            wr(DR_TAB[i], 8'h3C);
            wr(SL_TAB[i], 8'h0F);
            @(posedge clk_in);
            #1;
            check({16'h0, pin_out[i]}, 24'h0000AC);
            hub_port_data_in[i] = 8'h5A;
            @(posedge clk_in);
            #1;
            check({16'h0, pin_out[i]}, 24'h00005C);
            rd_chk(DR_TAB[i], 8'h3C, 1'b1);
            rd_chk(SL_TAB[i], 8'h0F, 1'b1);
        end
        // hub path reaches the same registers
        hub_op(1'b1, 4'h2, xsfr_pkg::XSFR_REG_DATA, 8'h77, q);
        rd_chk(DR_TAB[2], 8'h77, 1'b1);
        hub_op(1'b0, 4'h8, xsfr_pkg::XSFR_REG_SEL, 8'h00, q);
        check({16'h0, q}, 24'h00000F);
        hub_op(1'b0, 4'h3, xsfr_pkg::XSFR_REG_STATE, 8'h00, q);
        check({16'h0, q}, 24'h000059);
        // pointer moves, selection and region boundaries
        wr(`XSFR_A_LO0, 8'h00);
        wr(`XSFR_A_HI0, 8'h50);
        wr(`XSFR_A_LO1, 8'hFF);
        wr(`XSFR_A_HI1, 8'h1F);
        wr(`XSFR_A_TOP, 8'hFF);
        wr(`XSFR_A_PAGE, 8'hFF);
        mv_chk(1'b0, 8'h00, 24'h005000, 5'h0A);
        ptr_chk(16'h5000);
        wr(`XSFR_A_PSEL, 8'h01);
        mv_chk(1'b0, 8'h00, 24'h001FFF, 5'h01);
        ptr_chk(16'h1FFF);
        u_xsfr_cpu_model.ptr_op(1'b0, 16'h0000);
        ptr_chk(16'h2000);
        mv_chk(1'b0, 8'h00, 24'h002000, 5'h00);
        rd_chk(`XSFR_A_HI1, 8'h20, 1'b1);
        rd_chk(`XSFR_A_HI0, 8'h50, 1'b1);
        wr(`XSFR_A_PSEL, 8'h00);
        u_xsfr_cpu_model.ptr_op(1'b1, 16'h4000);
        ptr_chk(16'h4000);
        mv_chk(1'b0, 8'h00, 24'h004000, 5'h02);
        wr(`XSFR_A_EXT0, 8'h80);
        mv_chk(1'b0, 8'h00, 24'h804000, 5'h16);
        wr(`XSFR_A_EXT0, 8'h7F);
        u_xsfr_cpu_model.ptr_op(1'b1, 16'hFFFF);
        mv_chk(1'b0, 8'h00, 24'h7FFFFF, 5'h00);
        ptr_chk(16'hFFFF);
        wr(`XSFR_A_EXT1, 8'h33);
        mv_chk(1'b1, 8'hFF, 24'hFFFFFF, 5'h16);
        wr(`XSFR_A_TOP, 8'h00);
        wr(`XSFR_A_PAGE, 8'h1F);
        mv_chk(1'b1, 8'hFE, 24'h001FFE, 5'h01);
        // internal data space steering
        idata_chk(1'b1, 8'h80, 1'b1);
        idata_chk(1'b0, 8'h80, 1'b0);
        idata_chk(1'b1, 8'h7F, 1'b0);
        print_verdict();
    end

endmodule
